// ===== common/sar_seq_pkg.sv
// constants and types shared by the conversion sequencer
package sar_seq_pkg;
	localparam int RES_BITS = 16;
	localparam logic [15:0] CODE_ZERO = 16'h0000;
	localparam logic [15:0] CODE_MID  = 16'h8000;
	localparam logic [15:0] CODE_FULL = 16'hFFFF;
	localparam logic [15:0] MSB_MASK  = 16'h8000;
	localparam logic [15:0] ALL_ONES  = 16'hFFFF;
	localparam int REF_CLK_MHZ = 200;
	// least throughput period in ns, and the derived cycle budget
	localparam int MIN_PERIOD_NS = 1000;
	localparam int MIN_PERIOD_CYC = (MIN_PERIOD_NS * REF_CLK_MHZ + 999) / 1000;
	// internal conversion clock divider: bit trial time in ns, and the ref_clk cycles it spans
	localparam int BIT_TIME_NS = 25;
	localparam int BIT_CYC = (BIT_TIME_NS * REF_CLK_MHZ) / 1000;
	localparam logic [7:0] BIT_CYC_M1 = 8'(BIT_CYC - 1);
	// settle gap between opening sample switches and switching arrays to ground
	localparam int SETTLE_NS = 10;
	localparam int SETTLE_CYC = (SETTLE_NS * REF_CLK_MHZ) / 1000;
	localparam logic [7:0] SETTLE_CYC_M1 = 8'(SETTLE_CYC - 1);
	localparam logic [7:0] CNT_ZERO = 8'h00;
	typedef enum logic [4:0] {
		ST_ACQ    = 5'h01,
		ST_OPEN   = 5'h02,
		ST_HOLD   = 5'h04,
		ST_TRIAL  = 5'h08,
		ST_FINISH = 5'h10
	} seq_state_t;
endpackage

// ===== hw/sar_conv_timer.sv
// internal conversion clock: a tick every bit period while enabled
`timescale 1ns/1ps
module sar_conv_timer (
	// clock and reset
	input  wire logic       ref_clk,
	input  wire logic       rst,
	// control
	input  wire logic       run,
	input  wire logic [7:0] period_m1,
	// tick out
	output logic            tick
);
	logic [7:0] cnt_q;
	logic [7:0] cnt_d;
	logic       tick_q;
	logic       tick_d;

	always_comb begin
		cnt_d  = sar_seq_pkg::CNT_ZERO;
		tick_d = 1'b0;
		if (run) begin
			if (cnt_q >= period_m1) begin
				tick_d = 1'b1;
			end else begin
				cnt_d = cnt_q + 8'h01;
			end
		end
	end

	always_ff @(posedge ref_clk) begin
		if (rst) begin
			cnt_q  <= sar_seq_pkg::CNT_ZERO;
			tick_q <= 1'b0;
		end else begin
			cnt_q  <= cnt_d;
			tick_q <= tick_d;
		end
	end

	assign tick = tick_q;
endmodule

// ===== hw/sar_conversion_sequencer.sv
// successive-approximation conversion sequencer
`timescale 1ns/1ps
module sar_conversion_sequencer (
	// clock and reset
	input  wire logic        ref_clk,
	input  wire logic        rst,
	// host side
	input  wire logic        convert_start,
	output logic [15:0]      result_code,
	output logic             conv_done,
	output logic             conv_busy,
	// analog side
	input  wire logic        comp_out,
	output logic             pos_sample_switch,
	output logic             neg_sample_switch,
	output logic             array_to_input,
	output logic [15:0]      dac_bits,
	output logic             conv_power_en
);
	// sequencer phase
	sar_seq_pkg::seq_state_t state_q;
	sar_seq_pkg::seq_state_t state_d;
	// convert input synchroniser and edge detect
	logic [1:0]  start_sync_q;
	logic [1:0]  start_sync_d;
	logic        start_prev_q;
	logic        start_prev_d;
	logic        start_rise;
	// comparator synchroniser
	logic [1:0]  comp_sync_q;
	logic [1:0]  comp_sync_d;
	logic        comp_keep;
	// successive-approximation datapath
	logic [15:0] sar_q;
	logic [15:0] sar_d;
	logic [15:0] trial_q;
	logic [15:0] trial_d;
	// published result
	logic [15:0] result_q;
	logic [15:0] result_d;
	logic        done_q;
	logic        done_d;
	// settle count after the sample switches open
	logic [7:0]  settle_q;
	logic [7:0]  settle_d;
	// registered switch and power controls
	logic        sample_sw_q;
	logic        sample_sw_d;
	logic        array_in_q;
	logic        array_in_d;
	logic [15:0] dac_q;
	logic [15:0] dac_d;
	logic        power_q;
	logic        power_d;
	logic        busy_q;
	logic        busy_d;
	// internal conversion clock
	logic        timer_run;
	logic        bit_tick;

	// true when the state code equals the wanted phase
	function automatic logic in_state(input sar_seq_pkg::seq_state_t st,
		input sar_seq_pkg::seq_state_t want);
		in_state = (st == want);
	endfunction

	// keep or drop the bit under trial, then raise the next lower one
	function automatic logic [15:0] decide_bit(input logic [15:0] code,
		input logic [15:0] trial, input logic keep);
		logic [15:0] kept;
		kept       = keep ? code : (code & ~trial);
		decide_bit = kept | (trial >> 1);
	endfunction

	// straight binary needs no offset; the search itself pins both ends
	function automatic logic [15:0] clamp_code(input logic [15:0] code);
		clamp_code = code;
	endfunction

	// conversion clock runs only for the trial phase
	assign timer_run = in_state(state_q, sar_seq_pkg::ST_TRIAL);

	sar_conv_timer sar_conv_timer_i (
		.ref_clk   (ref_clk),
		.rst       (rst),
		.run       (timer_run),
		.period_m1 (sar_seq_pkg::BIT_CYC_M1),
		.tick      (bit_tick)
	);

	// convert input: two flops, then edge detect on the second stage
	always_comb begin
		start_sync_d = {start_sync_q[0], convert_start};
		start_prev_d = start_sync_q[1];
	end

	always_ff @(posedge ref_clk) begin
		if (rst) begin
			start_sync_q <= 2'b00;
			start_prev_q <= 1'b0;
		end else begin
			start_sync_q <= start_sync_d;
			start_prev_q <= start_prev_d;
		end
	end

	assign start_rise = start_sync_q[1] & ~start_prev_q;

	// comparator settles well inside a bit period, so two flops cost nothing
	always_comb begin
		comp_sync_d = {comp_sync_q[0], comp_out};
	end

	always_ff @(posedge ref_clk) begin
		if (rst) begin
			comp_sync_q <= 2'b00;
		end else begin
			comp_sync_q <= comp_sync_d;
		end
	end

	assign comp_keep = comp_sync_q[1];

	// phase sequencing
	always_comb begin
		state_d = state_q;
		unique case (state_q)
			sar_seq_pkg::ST_ACQ: begin
				// edges while converting are never seen here, so a run always ends
				if (start_rise) begin
					state_d = sar_seq_pkg::ST_OPEN;
				end
			end
			sar_seq_pkg::ST_OPEN: begin
				// sample switches already open, arrays still on the inputs
				if (settle_q >= sar_seq_pkg::SETTLE_CYC_M1) begin
					state_d = sar_seq_pkg::ST_HOLD;
				end
			end
			sar_seq_pkg::ST_HOLD: begin
				state_d = sar_seq_pkg::ST_TRIAL;
			end
			sar_seq_pkg::ST_TRIAL: begin
				if (bit_tick && trial_q[0]) begin
					state_d = sar_seq_pkg::ST_FINISH;
				end
			end
			sar_seq_pkg::ST_FINISH: begin
				state_d = sar_seq_pkg::ST_ACQ;
			end
		endcase
	end

	always_ff @(posedge ref_clk) begin
		if (rst) begin
			state_q <= sar_seq_pkg::ST_ACQ;
		end else begin
			state_q <= state_d;
		end
	end

	// settle count runs only while the sample switches are open
	always_comb begin
		settle_d = sar_seq_pkg::CNT_ZERO;
		if (in_state(state_q, sar_seq_pkg::ST_OPEN)) begin
			settle_d = settle_q + 8'h01;
		end
	end

	always_ff @(posedge ref_clk) begin
		if (rst) begin
			settle_q <= sar_seq_pkg::CNT_ZERO;
		end else begin
			settle_q <= settle_d;
		end
	end

	// trial weight walks from the top bit down to the bottom one
	always_comb begin
		trial_d = trial_q;
		if (in_state(state_q, sar_seq_pkg::ST_HOLD)) begin
			trial_d = sar_seq_pkg::MSB_MASK;
		end else if (in_state(state_q, sar_seq_pkg::ST_TRIAL) && bit_tick) begin
			trial_d = trial_q >> 1;
		end
	end

	always_ff @(posedge ref_clk) begin
		if (rst) begin
			trial_q <= sar_seq_pkg::CODE_ZERO;
		end else begin
			trial_q <= trial_d;
		end
	end

	// a fresh search per sample, nothing carried from the last result
	always_comb begin
		sar_d = sar_q;
		if (in_state(state_q, sar_seq_pkg::ST_HOLD)) begin
			sar_d = sar_seq_pkg::MSB_MASK;
		end else if (in_state(state_q, sar_seq_pkg::ST_TRIAL) && bit_tick) begin
			sar_d = decide_bit(sar_q, trial_q, comp_keep);
		end
	end

	always_ff @(posedge ref_clk) begin
		if (rst) begin
			sar_q <= sar_seq_pkg::CODE_ZERO;
		end else begin
			sar_q <= sar_d;
		end
	end

	// result taken only once the last decision is in
	always_comb begin
		result_d = result_q;
		if (in_state(state_q, sar_seq_pkg::ST_FINISH)) begin
			result_d = clamp_code(sar_q);
		end
	end

	always_ff @(posedge ref_clk) begin
		if (rst) begin
			result_q <= sar_seq_pkg::CODE_ZERO;
		end else begin
			result_q <= result_d;
		end
	end

	// end-of-conversion pulse, on the edge that loads the result
	always_comb begin
		done_d = in_state(state_q, sar_seq_pkg::ST_FINISH);
	end

	always_ff @(posedge ref_clk) begin
		if (rst) begin
			done_q <= 1'b0;
		end else begin
			done_q <= done_d;
		end
	end

	// controls registered from the next phase, so they change with it
	always_comb begin
		sample_sw_d = in_state(state_d, sar_seq_pkg::ST_ACQ);
		array_in_d  = in_state(state_d, sar_seq_pkg::ST_ACQ)
			| in_state(state_d, sar_seq_pkg::ST_OPEN);
	end

	always_ff @(posedge ref_clk) begin
		if (rst) begin
			sample_sw_q <= 1'b1;
			array_in_q  <= 1'b1;
		end else begin
			sample_sw_q <= sample_sw_d;
			array_in_q  <= array_in_d;
		end
	end

	always_comb begin
		dac_d = sar_seq_pkg::CODE_ZERO;
		if (in_state(state_d, sar_seq_pkg::ST_TRIAL)) begin
			dac_d = sar_d;
		end
	end

	always_ff @(posedge ref_clk) begin
		if (rst) begin
			dac_q <= sar_seq_pkg::CODE_ZERO;
		end else begin
			dac_q <= dac_d;
		end
	end

	always_comb begin
		power_d = !in_state(state_d, sar_seq_pkg::ST_ACQ);
		busy_d  = !in_state(state_d, sar_seq_pkg::ST_ACQ);
	end

	always_ff @(posedge ref_clk) begin
		if (rst) begin
			power_q <= 1'b0;
			busy_q  <= 1'b0;
		end else begin
			power_q <= power_d;
			busy_q  <= busy_d;
		end
	end

	assign pos_sample_switch = sample_sw_q;
	assign neg_sample_switch = sample_sw_q;
	assign array_to_input    = array_in_q;
	assign dac_bits          = dac_q;
	// analog powered only while converting
	assign conv_power_en     = power_q;
	assign conv_busy         = busy_q;
	assign result_code       = result_q;
	assign conv_done         = done_q;
endmodule

// ===== verif/sar_seq_monitor.sv
// port assertions for the conversion sequencer
`timescale 1ns/1ps
module sar_seq_monitor (
	// clock and reset
	input wire logic        ref_clk,
	input wire logic        rst,
	// host side
	input wire logic        convert_start,
	input wire logic [15:0] result_code,
	input wire logic        conv_done,
	input wire logic        conv_busy,
	// analog side
	input wire logic        comp_out,
	input wire logic        pos_sample_switch,
	input wire logic        neg_sample_switch,
	input wire logic        array_to_input,
	input wire logic [15:0] dac_bits,
	input wire logic        conv_power_en
);
	default clocking @(posedge ref_clk); endclocking
	default disable iff (rst);
	a_acq_switches: assert property (
		!conv_busy |-> pos_sample_switch && neg_sample_switch && array_to_input && !dac_bits)
		else $error("acquisition switches wrong");
	a_start_cause: assert property (
		$rose(conv_busy) |-> $past(convert_start, 3)) else $error("start without request");
	a_open_first: assert property (
		$rose(conv_busy) |-> !pos_sample_switch && !neg_sample_switch && array_to_input)
		else $error("sample switches not opened first");
	a_ground_next: assert property (
		$rose(conv_busy) |-> ##1 array_to_input ##1 !array_to_input)
		else $error("arrays not grounded after opening");
	a_msb_first: assert property (
		$fell(array_to_input) |=> dac_bits == 16'h8000) else $error("first trial not msb");
	a_done_acq: assert property (
		conv_done |-> $fell(conv_busy) && pos_sample_switch) else $error("done outside return");
	a_code_held: assert property (
		!conv_done |-> $stable(result_code)) else $error("code changed without done");
	a_power_busy: assert property (
		conv_power_en == conv_busy) else $error("power not following conversion");
	a_bounded_run: assert property (
		$rose(conv_busy) |-> ##85 conv_done) else $error("conversion did not finish");
endmodule

bind sar_conversion_sequencer sar_seq_monitor sar_seq_monitor_i (.*);

// ===== verif/sar_analog_model.sv
// comparator and capacitor arrays seen from the sequencer
`timescale 1ns/1ps
module sar_analog_model (
	// clock
	input wire logic               ref_clk,
	// analog input and switches
	input wire logic signed [17:0] vin,
	input wire logic               pos_sample_switch,
	input wire logic [15:0]        dac_bits,
	// comparator
	output logic                   comp_out
);
	logic signed [17:0] held_q;
	// tracks the input only while sampling, so later changes are not seen
	always_ff @(posedge ref_clk) if (pos_sample_switch) held_q <= vin;
	assign comp_out = $signed({2'b00, dac_bits}) <= held_q;
endmodule

// ===== verif/sar_conversion_sequencer_tb.sv
// self-checking bench for the conversion sequencer
`timescale 1ns/1ps
module sar_conversion_sequencer_tb;
	logic ref_clk = 1'b0, rst = 1'b1, convert_start = 1'b0;
	logic signed [17:0] vin = 18'sh0;
	logic comp_out, conv_done, conv_busy, pos_sw, neg_sw, arr_in, pwr;
	logic [15:0] result_code, dac_bits;
	int failures = 0, total_checks = 0;
	always #2.5 ref_clk = ~ref_clk;
	sar_conversion_sequencer sar_conversion_sequencer_i (.ref_clk(ref_clk), .rst(rst),
		.convert_start(convert_start), .result_code(result_code), .conv_done(conv_done),
		.conv_busy(conv_busy), .comp_out(comp_out), .pos_sample_switch(pos_sw),
		.neg_sample_switch(neg_sw), .array_to_input(arr_in), .dac_bits(dac_bits),
		.conv_power_en(pwr));
	sar_analog_model sar_analog_model_i (.ref_clk(ref_clk), .vin(vin),
		.pos_sample_switch(pos_sw), .dac_bits(dac_bits), .comp_out(comp_out));
	task automatic check(input string what, input logic [15:0] exp, input logic [15:0] got);
		total_checks++;
		if (got !== exp) begin
			failures++;
			$display("Error %s expected %h seen %h", what, exp, got);
		end
	endtask
	task automatic print_verdict;
		$display("checks %0d mismatches %0d", total_checks, failures);
		if (failures == 0 && total_checks > 0) $display("Result: passed");
		else $display("Result: failed");
		$finish;
	endtask
	// one conversion; input moves and start toggles while busy
	task automatic convert(input logic signed [17:0] v, late, input logic [15:0] exp);
		int n = 0;
		@(posedge ref_clk);
		vin <= v;
		convert_start <= 1'b1;
		while (conv_done !== 1'b1 && n < 300) begin
			@(posedge ref_clk);
			n++;
			if (n == 8) vin <= late;
			if (n == 20 || n == 40) convert_start <= 1'b0;
			if (n == 30) convert_start <= 1'b1;
		end
		check("code", exp, result_code);
		check("in_time", 16'h0001, {15'h0, n < 200});
		repeat (10) @(posedge ref_clk);
		check("idle", 16'h0000, {15'h0, conv_busy});
	endtask
	task automatic t_codes;
		logic signed [17:0] v[9] = '{0, 1, 'h7FFF, 'h8000, 'h8001, 'hFFFF, 'h10000, 'h1FFFF, -5};
		logic [15:0] e[9] = '{0, 1, 'h7FFF, 'h8000, 'h8001, 'hFFFF, 'hFFFF, 'hFFFF, 0};
		for (int i = 0; i < 9; i++) convert(v[i], v[i], e[i]);
		$display("t_codes done");
	endtask
	task automatic t_latency;
		convert(18'sh1234, 18'sh4321, 16'h1234);
		convert(18'sh4321, 18'sh0, 16'h4321);
		$display("t_latency done");
	endtask
	task automatic t_reset;
		@(posedge ref_clk);
		convert_start <= 1'b1;
		repeat (50) @(posedge ref_clk);
		rst <= 1'b1;
		repeat (2) @(posedge ref_clk);
		check("busy_rst", 16'h0000, {15'h0, conv_busy});
		check("code_rst", 16'h0000, result_code);
		rst <= 1'b0;
		convert_start <= 1'b0;
		$display("t_reset done");
	endtask
	initial begin
		repeat (4) @(posedge ref_clk);
		rst <= 1'b0;
		t_codes();
		t_latency();
		t_reset();
		convert(18'sh0ABC, 18'sh0ABC, 16'h0ABC);
		print_verdict();
	end
	initial begin
		#40000;
		failures++;
		print_verdict();
	end
endmodule
